// ==== pme_consts.vh ====
// Constants for the programming mode entry block
`ifndef PME_CONSTS_VH
`define PME_CONSTS_VH
// Length of the low-voltage entry key in bits
`define PME_KEY_BITS 32
// Default entry key value (arbitrary value, not tied to any part)
`define PME_KEY_DEFAULT 32'h5a3c_96e1
// Reset value of the entry enable bit (erased state is 1)
`define PME_LVE_RESET 1'b1
// Mode encodings
`define PME_MODE_RUN 2'h0
`define PME_MODE_HV 2'h1
`define PME_MODE_LV 2'h2
`define PME_MODE_LOCK 2'h3
`endif

// ==== pme_pin_sync.v ====
// Three-stage pin synchroniser with agreement filter
module pme_pin_sync (
   input wire clk_in,
   input wire srst_in,
   input wire pin_in,
   output reg level_out,
   output reg rise_out,
   output reg fall_out
);
   // First stage is read only by the second
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // Shift chain and filtered level; a change counts when stages two and three agree
   always @(posedge clk_in) begin
      if (srst_in) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_out <= 1'b0;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
         // Agreement reached on a new value
         if ((s2_reg == s3_reg) && (s3_reg != level_out)) begin
            level_out <= s3_reg;
            rise_out <= s3_reg;
            fall_out <= ~s3_reg;
         end
      end
   end
endmodule // pme_pin_sync

// ==== pme_entry.v ====
// Programming mode entry logic: high-voltage and low-voltage key entry
`include "pme_consts.vh"
module pme_entry #(
   parameter KEY_BITS = `PME_KEY_BITS,
   parameter [KEY_BITS-1:0] ENTRY_KEY = `PME_KEY_DEFAULT
) (
   input wire REF_CLK_IN,
   input wire SRST_IN,
   input wire PROG_SERIAL_CLOCK_IN,
   input wire PROG_SERIAL_DATA_IN,
   input wire MASTER_CLEAR_RESET_PIN_IN,
   input wire HIGH_VOLTAGE_IN,
   input wire RESET_FUNC_CFG_IN,
   input wire CLEAR_LVE_REQ_IN,
   input wire DATA_OUT_VALUE_IN,
   input wire DATA_OUT_ENABLE_IN,
   output reg PROG_SERIAL_DATA_OUT,
   output reg PROG_SERIAL_DATA_OE_OUT,
   output reg PROG_MODE_OUT,
   output reg HV_SESSION_OUT,
   output reg LV_SESSION_OUT,
   output reg LOW_VOLTAGE_ENTRY_ENABLE_OUT,
   output reg RESET_FUNC_EN_OUT,
   output reg KEY_FAIL_OUT
);
   // Synchronised pin levels and edges
   wire clk_level;
   wire clk_rise;
   wire dat_level;
   wire master_clear_reset_pin_level;
   wire master_clear_reset_pin_rise;
   wire master_clear_reset_pin_fall;
   wire hv_level;
   // Mode state and its next value
   reg [1:0] mode_reg;
   reg [1:0] mode_next;
   // Key shift register and bit counter
   reg [KEY_BITS-1:0] shift_reg;
   reg [KEY_BITS-1:0] shift_next;
   reg [5:0] count_reg;
   reg [5:0] count_next;
   // Entry enable configuration bit
   reg lve_reg;
   reg lve_next;
   // Mode state codes, binary
   localparam [1:0] MODE_RUN = `PME_MODE_RUN;
   localparam [1:0] MODE_HV = `PME_MODE_HV;
   localparam [1:0] MODE_LV = `PME_MODE_LV;
   localparam [1:0] MODE_LOCK = `PME_MODE_LOCK;

   // Decode of the two session states, shared by the mode and drive outputs
   function in_session;
      input [1:0] mode;
      begin
         in_session = (mode == MODE_HV) || (mode == MODE_LV);
      end
   endfunction

   // Serial clock synchroniser; edges found on the local clock
   pme_pin_sync u_clk_sync (
      .clk_in(REF_CLK_IN),
      .srst_in(SRST_IN),
      .pin_in(PROG_SERIAL_CLOCK_IN),
      .level_out(clk_level),
      .rise_out(clk_rise),
      .fall_out()
   );

   // Serial data synchroniser
   pme_pin_sync u_dat_sync (
      .clk_in(REF_CLK_IN),
      .srst_in(SRST_IN),
      .pin_in(PROG_SERIAL_DATA_IN),
      .level_out(dat_level),
      .rise_out(),
      .fall_out()
   );

   // Reset pin synchroniser
   pme_pin_sync u_master_clear_reset_pin_sync (
      .clk_in(REF_CLK_IN),
      .srst_in(SRST_IN),
      .pin_in(MASTER_CLEAR_RESET_PIN_IN),
      .level_out(master_clear_reset_pin_level),
      .rise_out(master_clear_reset_pin_rise),
      .fall_out(master_clear_reset_pin_fall)
   );

   // High-voltage detector synchroniser
   pme_pin_sync u_hv_sync (
      .clk_in(REF_CLK_IN),
      .srst_in(SRST_IN),
      .pin_in(HIGH_VOLTAGE_IN),
      .level_out(hv_level),
      .rise_out(),
      .fall_out()
   );

   // Next-state logic for mode, key shifter and enable bit
   always @* begin
      // Hold everything unless a branch below says otherwise
      mode_next = mode_reg;
      shift_next = shift_reg;
      count_next = count_reg;
      lve_next = lve_reg;
      case (mode_reg)
         MODE_RUN: begin
            if (master_clear_reset_pin_rise && hv_level && !clk_level && !dat_level) begin
               mode_next = MODE_HV;
            end else if (lve_reg && !master_clear_reset_pin_level) begin
               if (clk_rise) begin
                  shift_next = {shift_reg[KEY_BITS-2:0], dat_level};
                  count_next = count_reg + 6'h01;
                  // Last key bit: judge the whole word at once
                  if (count_reg == KEY_BITS - 1) begin
                     count_next = 6'h00;
                     if ({shift_reg[KEY_BITS-2:0], dat_level} == ENTRY_KEY) begin
                        mode_next = MODE_LV;
                     end else begin
                        mode_next = MODE_LOCK;
                     end
                  end
               end
            end else begin
               shift_next = {KEY_BITS{1'b0}};
               count_next = 6'h00;
            end
         end
         MODE_HV: begin
            if (CLEAR_LVE_REQ_IN) begin
               lve_next = 1'b0;
            end
            // Session ends when high voltage or the pin drops
            if (!hv_level || master_clear_reset_pin_fall) begin
               mode_next = MODE_RUN;
            end
         end
         MODE_LV: begin
            if (master_clear_reset_pin_level) begin
               mode_next = MODE_RUN;
               shift_next = {KEY_BITS{1'b0}};
            end
         end
         default: begin
            shift_next = {KEY_BITS{1'b0}};
            count_next = 6'h00;
            // Pin rise ends the lockout
            if (master_clear_reset_pin_rise) begin
               if (hv_level && !clk_level && !dat_level) begin
                  mode_next = MODE_HV;
               end else begin
                  // Plain release returns to normal running
                  mode_next = MODE_RUN;
               end
            end
         end
      endcase
   end

   // State registers
   always @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         // Reset returns to normal running with the erased enable bit
         mode_reg <= MODE_RUN;
         shift_reg <= {KEY_BITS{1'b0}};
         count_reg <= 6'h00;
         lve_reg <= `PME_LVE_RESET;
      end else begin
         mode_reg <= mode_next;
         shift_reg <= shift_next;
         count_reg <= count_next;
         lve_reg <= lve_next;
      end
   end

   // Registered outputs
   always @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         PROG_SERIAL_DATA_OUT <= 1'b0;
         PROG_SERIAL_DATA_OE_OUT <= 1'b0;
         PROG_MODE_OUT <= 1'b0;
         HV_SESSION_OUT <= 1'b0;
         LV_SESSION_OUT <= 1'b0;
         LOW_VOLTAGE_ENTRY_ENABLE_OUT <= `PME_LVE_RESET;
         RESET_FUNC_EN_OUT <= 1'b1;
         KEY_FAIL_OUT <= 1'b0;
      end else begin
         PROG_SERIAL_DATA_OUT <= DATA_OUT_VALUE_IN;
         PROG_SERIAL_DATA_OE_OUT <= DATA_OUT_ENABLE_IN && in_session(mode_next);
         // Session flags follow the next state so they land with the state register
         PROG_MODE_OUT <= in_session(mode_next);
         HV_SESSION_OUT <= (mode_next == MODE_HV);
         LV_SESSION_OUT <= (mode_next == MODE_LV);
         LOW_VOLTAGE_ENTRY_ENABLE_OUT <= lve_next;
         RESET_FUNC_EN_OUT <= lve_next | RESET_FUNC_CFG_IN;
         KEY_FAIL_OUT <= (mode_next == MODE_LOCK);
      end
   end
endmodule // pme_entry

// ==== pme_entry_assertions.sv ====
// Checker of port relations for the programming mode entry block
module pme_entry_assertions (
   input wire REF_CLK_IN,
   input wire SRST_IN,
   input wire MASTER_CLEAR_RESET_PIN_IN,
   input wire HIGH_VOLTAGE_IN,
   input wire PROG_SERIAL_DATA_OE_OUT,
   input wire PROG_MODE_OUT,
   input wire HV_SESSION_OUT,
   input wire LV_SESSION_OUT,
   input wire LOW_VOLTAGE_ENTRY_ENABLE_OUT,
   input wire RESET_FUNC_EN_OUT,
   input wire KEY_FAIL_OUT
);
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SRST_IN);
   a_hv_needs_high: assert property (!HIGH_VOLTAGE_IN [*8] |-> !HV_SESSION_OUT)
      else $error("hv session without high voltage");
   a_mode_from_session: assert property (PROG_MODE_OUT == (HV_SESSION_OUT | LV_SESSION_OUT))
      else $error("mode and session disagree");
   a_lv_needs_enable: assert property ($rose(LV_SESSION_OUT) |-> LOW_VOLTAGE_ENTRY_ENABLE_OUT)
      else $error("lv entry while disabled");
   a_lv_pin_low: assert property (MASTER_CLEAR_RESET_PIN_IN [*8] |-> !LV_SESSION_OUT)
      else $error("lv session with pin high");
   a_reset_func_forced: assert property (LOW_VOLTAGE_ENTRY_ENABLE_OUT |-> RESET_FUNC_EN_OUT)
      else $error("reset function off while enabled");
   a_clear_hv_only: assert property ($fell(LOW_VOLTAGE_ENTRY_ENABLE_OUT) |-> $past(HV_SESSION_OUT))
      else $error("enable cleared outside hv");
   a_oe_in_session: assert property (PROG_SERIAL_DATA_OE_OUT |-> PROG_MODE_OUT || $past(PROG_MODE_OUT))
      else $error("data driven outside session");
   a_fail_no_session: assert property (KEY_FAIL_OUT |-> !LV_SESSION_OUT)
      else $error("lv session during lockout");
   c_hv: cover property ($rose(HV_SESSION_OUT));
   c_lv: cover property ($rose(LV_SESSION_OUT));
   c_fail: cover property ($rose(KEY_FAIL_OUT));
endmodule // pme_entry_assertions
bind pme_entry pme_entry_assertions u_chk (.REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN),
   .MASTER_CLEAR_RESET_PIN_IN(MASTER_CLEAR_RESET_PIN_IN), .HIGH_VOLTAGE_IN(HIGH_VOLTAGE_IN),
   .PROG_SERIAL_DATA_OE_OUT(PROG_SERIAL_DATA_OE_OUT), .PROG_MODE_OUT(PROG_MODE_OUT),
   .HV_SESSION_OUT(HV_SESSION_OUT), .LV_SESSION_OUT(LV_SESSION_OUT),
   .LOW_VOLTAGE_ENTRY_ENABLE_OUT(LOW_VOLTAGE_ENTRY_ENABLE_OUT),
   .RESET_FUNC_EN_OUT(RESET_FUNC_EN_OUT), .KEY_FAIL_OUT(KEY_FAIL_OUT));

// ==== pme_prog_model.sv ====
// Behavioural model of the external programmer on the serial pins
module pme_prog_model (
   input wire logic clk_in,
   output logic sclk_out,
   output logic sdat_out,
   output logic master_clear_reset_pin_out,
   output logic hv_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {sclk_out, sdat_out, master_clear_reset_pin_out, hv_out} = 4'h0;
   // Drive clock, data, reset pin, high voltage just after an edge
   task automatic pins(input logic [3:0] v);
      @(posedge clk_in);
      #1 {sclk_out, sdat_out, master_clear_reset_pin_out, hv_out} = v;
   endtask
   task automatic hv_enter();
      pins(4'h1);
      pins(4'h3);
   endtask
   task automatic key(input logic [31:0] k);
      pins(4'h0);
      repeat (8) @(posedge clk_in);
      for (int i = 31; i >= 0; i--) begin
         pins({1'b0, k[i], 2'h0});
         repeat (7) @(posedge clk_in);
         pins({1'b1, k[i], 2'h0});
         repeat (7) @(posedge clk_in);
      end
      pins(4'h0);
   endtask
endmodule // pme_prog_model

// ==== pme_entry_bench.sv ====
// Self-checking bench for the programming mode entry block
`include "pme_consts.vh"
module pme_entry_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, srst = 1'b1, cfg = 1'b0, clr = 1'b0, dval = 1'b0, den = 1'b0;
   wire sclk, sdat, master_clear_reset_pin, hv, dout, doe, mode, hvs, lvs, en, rfe, fail;
   int num_errors = 0;
   int comparisons = 0;
   logic [31:0] k;
   always #2.5 clk = ~clk;
   pme_prog_model prog (.clk_in(clk), .sclk_out(sclk), .sdat_out(sdat), .master_clear_reset_pin_out(master_clear_reset_pin),
      .hv_out(hv));
   // data line level from both drivers
   pme_entry dut (.REF_CLK_IN(clk), .SRST_IN(srst), .PROG_SERIAL_CLOCK_IN(sclk),
      .PROG_SERIAL_DATA_IN(doe ? dout : sdat), .MASTER_CLEAR_RESET_PIN_IN(master_clear_reset_pin),
      .HIGH_VOLTAGE_IN(hv), .RESET_FUNC_CFG_IN(cfg), .CLEAR_LVE_REQ_IN(clr),
      .DATA_OUT_VALUE_IN(dval), .DATA_OUT_ENABLE_IN(den), .PROG_SERIAL_DATA_OUT(dout),
      .PROG_SERIAL_DATA_OE_OUT(doe), .PROG_MODE_OUT(mode), .HV_SESSION_OUT(hvs),
      .LV_SESSION_OUT(lvs), .LOW_VOLTAGE_ENTRY_ENABLE_OUT(en), .RESET_FUNC_EN_OUT(rfe),
      .KEY_FAIL_OUT(fail));
   // Compare one output level
   task automatic chk(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   // Let pin changes pass the synchroniser
   task automatic pause();
      repeat (12) @(posedge clk);
      #1;
   endtask
   // Counts, verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence of tests
   initial begin
      k = $urandom(32'h581d);
      k = $urandom;
      cfg = k[1];
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      repeat (5) @(posedge clk);
      // High-voltage session, data driven back, enable cleared
      prog.hv_enter();
      den = 1'b1;
      dval = k[0];
      pause();
      chk(hvs, 1'b1);
      chk(mode, 1'b1);
      chk(doe, 1'b1);
      chk(dout, k[0]);
      clr = 1'b1;
      pause();
      chk(en, 1'b0);
      chk(rfe, cfg);
      cfg = ~cfg;
      pause();
      chk(rfe, cfg);
      clr = 1'b0;
      den = 1'b0;
      prog.pins(4'h0);
      pause();
      chk(mode, 1'b0);
      $display("hv test done");
      // Good key refused while enable is clear
      prog.key(`PME_KEY_DEFAULT);
      pause();
      chk(lvs, 1'b0);
      // Second reset restores the erased enable bit; other setting off
      srst = 1'b1;
      cfg = 1'b0;
      pause();
      srst = 1'b0;
      pause();
      chk(en, 1'b1);
      chk(rfe, 1'b1);
      $display("disabled test done");
      // Good key opens a session, clear request ignored there
      prog.key(`PME_KEY_DEFAULT);
      clr = 1'b1;
      pause();
      chk(lvs, 1'b1);
      chk(en, 1'b1);
      clr = 1'b0;
      prog.pins(4'h2);
      pause();
      chk(lvs, 1'b0);
      // One random bit flipped locks entry until the pin rises
      prog.key(`PME_KEY_DEFAULT ^ (32'h1 << k[6:2]));
      pause();
      chk(fail, 1'b1);
      prog.key(`PME_KEY_DEFAULT);
      pause();
      chk(lvs, 1'b0);
      prog.pins(4'h2);
      pause();
      chk(fail, 1'b0);
      $display("lv test done");
      stop_test();
   end
   // Watchdog well beyond four keys of 32 bits
   initial begin
      #60000;
      num_errors++;
      stop_test();
   end
endmodule // pme_entry_bench
